// File: core/serial_mode2_cfg.svh
// constants for the second mode-control and status register of the serial channel
// assumes inclusion by bare name from the package and the design modules
`ifndef SERIAL_MODE2_CFG_SVH
`define SERIAL_MODE2_CFG_SVH

// register map (word addresses on the plain register port)
`define ADDR_MODE2        8'h00
`define ADDR_IRQ_STATUS   8'h04
`define ADDR_IRQ_MASK     8'h08
`define ADDR_CTRL         8'h0c
`define ADDR_ERROR        8'h10
`define ADDR_TXDATA       8'h14
`define ADDR_RXDATA       8'h18

// mode2 field positions
`define BIT_TBEMP         7
`define BIT_RBFLL         6
`define BIT_TXRUN         5
`define BIT_SBLEN         4
`define BIT_ORDER         3
`define BIT_WBUF          2
`define BIT_SOFT_RESET_FIELD_HI      1
`define BIT_SOFT_RESET_FIELD_LO      0

// control register field positions
`define BIT_RXE           0
`define BIT_TXE           1
`define BIT_IOMODE        2
`define BIT_SCLKOUT       3

// interrupt status bits
`define IRQ_TXEMPTY       0
`define IRQ_RXFULL        1
`define IRQ_OVERRUN       2
`define IRQ_FRAMING       3

// soft reset codes
`define SOFT_RESET_FIELD_ARM         2'b10
`define SOFT_RESET_FIELD_FIRE        2'b01

// reset values
`define MODE2_RESET       8'h80

// timing: delay from recognition to execution, and bit period in clocks
`define SOFT_RESET_FIELD_DELAY_CYC   2
`define BAUD_DIV          16'd16

`endif

// File: core/serial_mode2_pkg.sv
// types shared by the serial mode2 block and its shifter
// assumes the cfg header sits in the include path
package serial_mode2_pkg;
   `include "serial_mode2_cfg.svh"

   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP1, TX_STOP2} txState_t;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rxState_t;
   typedef logic [7:0] byte_t;
endpackage

// File: core/serial_rx_shift.sv
// uart / clocked-io receive shifter with a single stop-bit check
// assumes rxd and sclk are already synchronised to mclk by the caller
`timescale 1ns/1ps
`default_nettype none
`include "serial_mode2_cfg.svh"

module serial_rx_shift
(
   // clock and reset
   input  wire logic                   mclk,
   input  wire logic                   rstn,
   input  wire logic                   clear,
   // configuration
   input  wire logic                   enable,
   input  wire logic                   ioMode,
   input  wire logic                   msbFirst,
   // line samples
   input  wire logic                   rxdSync,
   input  wire logic                   sclkRise,
   // result
   output logic                        wordDone,
   output logic                        frameErr,
   output serial_mode2_pkg::byte_t     wordOut
);
   import serial_mode2_pkg::*;

   rxState_t    state_reg;
   logic [15:0] baud_reg;
   logic [2:0]  bit_reg;
   byte_t       shift_reg;

   // uart samples mid-bit, io mode samples on the link clock rising edge
   wire tick       = ioMode ? sclkRise : (baud_reg == 16'd0);
   wire halfPoint  = (baud_reg == (`BAUD_DIV >> 1));
   wire [7:0] shin = msbFirst ? {shift_reg[6:0], rxdSync} : {rxdSync, shift_reg[7:1]};

   // receive sequencer
   always_ff @(posedge mclk)
   begin
      wordDone <= 1'b0;
      frameErr <= 1'b0;
      if (!rstn || clear || !enable)
      begin
         state_reg <= RX_IDLE;
         baud_reg  <= 16'd0;
         bit_reg   <= 3'd0;
         shift_reg <= 8'h00;
         if (!rstn) wordOut <= 8'h00;
      end
      else
      begin
         baud_reg <= (baud_reg == 16'd0) ? `BAUD_DIV - 16'd1 : baud_reg - 16'd1;
         case (state_reg)
            RX_IDLE:
               if (ioMode)
               begin
                  if (sclkRise)
                  begin
                     shift_reg <= shin;
                     bit_reg   <= 3'd1;
                     state_reg <= RX_DATA;
                  end
               end
               else if (!rxdSync)
               begin
                  baud_reg  <= `BAUD_DIV - 16'd1;
                  state_reg <= RX_START;
               end
            RX_START:
               if (halfPoint)
               begin
                  baud_reg  <= `BAUD_DIV - 16'd1;
                  state_reg <= rxdSync ? RX_IDLE : RX_DATA;
                  bit_reg   <= 3'd0;
               end
            RX_DATA:
               if (tick)
               begin
                  shift_reg <= shin;
                  bit_reg   <= bit_reg + 3'd1;
                  if (bit_reg == 3'd7)
                  begin
                     if (ioMode)
                     begin
                        wordOut   <= shin;
                        wordDone  <= 1'b1;
                        state_reg <= RX_IDLE;
                     end
                     else
                        state_reg <= RX_STOP;
                  end
               end
            RX_STOP:
               if (tick)
               begin
                  wordOut   <= shift_reg;
                  wordDone  <= 1'b1;
                  frameErr  <= !rxdSync;
                  state_reg <= RX_IDLE;
               end
            default: state_reg <= RX_IDLE;
         endcase
      end
   end
endmodule

`default_nettype wire

// File: core/serial_mode2_status_control.sv
// serial channel mode2 register: buffer status, stop length, bit order,
// double buffering and the two-write software reset, with a small tx/rx path
// assumes a plain register port on mclk; rxd and sclk pins are asynchronous
//
// Overview of operation
// - tx empty flag sets once buffer moves into shift register
// - writing new tx data clears the tx empty flag
// - empty and full flags meaningless while double buffering is off
// - rx full flag sets when a received word moves into buffer
// - reading the mode2 register clears the rx full flag
// - tx run flag is high while sending, low when stopped
// - uart transmit sends one stop bit, or two when stop length set
// - receiver checks only one stop bit regardless of stop length
// - io mode shifts lsb first at order 0, msb first at 1
// - double-buffer bit selects buffering for io tx, io rx out, uart tx
// - uart rx and io rx on external clock are always double buffered
// - writing 10 then 01 to the reset field triggers soft reset
// - soft reset clears enables, rx full, tx run and error flags, and sets tx empty
// - soft reset executes two clocks after the sequence is recognised
//
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "serial_mode2_cfg.svh"

module serial_mode2_status_control
(
   // clock and reset
   input  wire logic                   mclk,
   input  wire logic                   rstn,
   // register port
   input  wire logic [7:0]             regAddr,
   input  wire logic [31:0]            regWdata,
   input  wire logic                   regWrite,
   input  wire logic                   regRead,
   output logic [31:0]                 regRdata,
   // serial link pins
   input  wire logic                   rxdPin,
   input  wire logic                   sclkPin,
   output logic                        txdPin,
   output logic                        sclkOut,
   output logic                        sclkOutEnN,
   // interrupt
   output logic                        irq
);
   import serial_mode2_pkg::*;

   // ==========================================================
   // register state
   logic        sblen_reg, order_reg, wbuf_reg;
   logic [1:0]  soft_reset_field_reg;
   logic        armed_reg;
   logic [1:0]  rstDelay_reg;
   logic        rxe_reg, txe_reg, ioMode_reg, sclkOutSel_reg;
   logic        tbemp_reg, rbfll_reg, txrun_reg;
   logic        oerr_reg, perr_reg, ferr_reg;
   logic [3:0]  irqStat_reg, irqMask_reg;
   byte_t       txBuf_reg, rxBuf_reg;
   logic        txBufValid_reg;

   // ==========================================================
   // pin synchronisers: first stage read only by second stage
   logic rxdMeta_reg, rxdSync_reg, sclkMeta_reg, sclkSync_reg, sclkPrev_reg;
   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         rxdMeta_reg  <= 1'b1;
         rxdSync_reg  <= 1'b1;
         sclkMeta_reg <= 1'b1;
         sclkSync_reg <= 1'b1;
         sclkPrev_reg <= 1'b1;
      end
      else
      begin
         rxdMeta_reg  <= rxdPin;
         rxdSync_reg  <= rxdMeta_reg;
         sclkMeta_reg <= sclkPin;
         sclkSync_reg <= sclkMeta_reg;
         sclkPrev_reg <= sclkSync_reg;
      end
   end
   wire extRise = sclkSync_reg & ~sclkPrev_reg;

   // ==========================================================
   // address decode
   function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
      hit = (a == b);
   endfunction
   wire wrMode2  = regWrite & hit(regAddr, `ADDR_MODE2);
   wire wrStat   = regWrite & hit(regAddr, `ADDR_IRQ_STATUS);
   wire wrMask   = regWrite & hit(regAddr, `ADDR_IRQ_MASK);
   wire wrCtrl   = regWrite & hit(regAddr, `ADDR_CTRL);
   wire wrTx     = regWrite & hit(regAddr, `ADDR_TXDATA);
   wire rdMode2  = regRead  & hit(regAddr, `ADDR_MODE2);
   wire rdRx     = regRead  & hit(regAddr, `ADDR_RXDATA);

   // ==========================================================
   // soft reset recognition and delay
   wire [1:0] newRst = regWdata[`BIT_SOFT_RESET_FIELD_HI:`BIT_SOFT_RESET_FIELD_LO];
   wire swFire = wrMode2 & armed_reg & (newRst == `SOFT_RESET_FIELD_FIRE);
   wire swExec = (rstDelay_reg == 2'd1);
   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         armed_reg    <= 1'b0;
         rstDelay_reg <= 2'd0;
      end
      else
      begin
         if (wrMode2)
            armed_reg <= (newRst == `SOFT_RESET_FIELD_ARM);
         if (swFire)
            rstDelay_reg <= 2'(`SOFT_RESET_FIELD_DELAY_CYC);
         else if (rstDelay_reg != 2'd0)
            rstDelay_reg <= rstDelay_reg - 2'd1;
      end
   end

   // ==========================================================
   // transmitter
   txState_t    txState_reg;
   logic [15:0] txBaud_reg;
   logic [2:0]  txBit_reg;
   byte_t       txShift_reg;
   logic        sclkDrv_reg;
   wire         txTick  = ioMode_reg ? (sclkOutSel_reg ? (txBaud_reg == 16'd0) & !sclkDrv_reg
                                                       : extRise)
                                     : (txBaud_reg == 16'd0);
   // io bit order; uart uses lsb first as software sets it
   wire         txBitOut = order_reg ? txShift_reg[7] : txShift_reg[0];
   wire byte_t  txShiftNx = order_reg ? {txShift_reg[6:0], 1'b0} : {1'b0, txShift_reg[7:1]};
   wire         txLoad  = (txState_reg == TX_IDLE) & txe_reg & txBufValid_reg;
   wire         txEnd   = txTick & ((txState_reg == TX_STOP2) |
                          (txState_reg == TX_STOP1 & !sblen_reg) |
                          (txState_reg == TX_DATA & ioMode_reg & txBit_reg == 3'd7));
   // single buffer refuses new data while shifting
   wire         txAccept = wrTx & (wbuf_reg | (txState_reg == TX_IDLE)) & !txBufValid_reg;

   // tx sequencer
   always_ff @(posedge mclk)
   begin
      if (!rstn || swExec)
      begin
         txState_reg <= TX_IDLE;
         txBaud_reg  <= 16'd0;
         txBit_reg   <= 3'd0;
         txShift_reg <= 8'h00;
         txdPin      <= 1'b1;
         sclkDrv_reg <= 1'b1;
      end
      else
      begin
         txBaud_reg <= (txBaud_reg == 16'd0) ? `BAUD_DIV - 16'd1 : txBaud_reg - 16'd1;
         if (ioMode_reg & sclkOutSel_reg & (txBaud_reg == 16'd0) & txState_reg == TX_DATA)
            sclkDrv_reg <= ~sclkDrv_reg;
         case (txState_reg)
            TX_IDLE:
               if (txLoad)
               begin
                  txShift_reg <= txBuf_reg;
                  txBaud_reg  <= `BAUD_DIV - 16'd1;
                  txState_reg <= ioMode_reg ? TX_DATA : TX_START;
                  txBit_reg   <= 3'd0;
                  if (ioMode_reg)
                     txdPin <= order_reg ? txBuf_reg[7] : txBuf_reg[0];
                  else
                     txdPin <= 1'b0;
               end
            TX_START:
               if (txTick)
               begin
                  txdPin      <= txBitOut;
                  txState_reg <= TX_DATA;
               end
            TX_DATA:
               if (txTick)
               begin
                  txShift_reg <= txShiftNx;
                  txBit_reg   <= txBit_reg + 3'd1;
                  if (txBit_reg == 3'd7)
                  begin
                     txdPin      <= 1'b1;
                     txState_reg <= ioMode_reg ? TX_IDLE : TX_STOP1;
                  end
                  else
                     txdPin <= order_reg ? txShift_reg[6] : txShift_reg[1];
               end
            TX_STOP1:
               if (txTick)
                  txState_reg <= sblen_reg ? TX_STOP2 : TX_IDLE;
            TX_STOP2:
               if (txTick)
                  txState_reg <= TX_IDLE;
            default: txState_reg <= TX_IDLE;
         endcase
      end
   end
   assign sclkOut    = sclkDrv_reg;
   assign sclkOutEnN = ~(ioMode_reg & sclkOutSel_reg);

   // ==========================================================
   // receiver
   logic  rxDone, rxFerr;
   byte_t rxWord;
   serial_rx_shift uRx
   (
      .mclk     (mclk),
      .rstn     (rstn),
      .clear    (swExec),
      .enable   (rxe_reg),
      .ioMode   (ioMode_reg),
      .msbFirst (order_reg),
      .rxdSync  (rxdSync_reg),
      .sclkRise (sclkOutSel_reg ? (txTick & !sclkDrv_reg) : extRise),
      .wordDone (rxDone),
      .frameErr (rxFerr),
      .wordOut  (rxWord)
   );
   // rx path always buffered except io with internal clock and no wbuf
   wire rxSingle = ioMode_reg & sclkOutSel_reg & !wbuf_reg;
   wire rxOver   = rxDone & rbfll_reg & !rdRx & !rxSingle;

   // ==========================================================
   // buffers and status flags; hardware set wins over clear
   always_ff @(posedge mclk)
   begin
      if (!rstn || swExec)
      begin
         tbemp_reg <= 1'b1;
         rbfll_reg <= 1'b0;
         txrun_reg <= 1'b0;
         oerr_reg  <= 1'b0;
         perr_reg  <= 1'b0;
         ferr_reg  <= 1'b0;
         txBufValid_reg <= 1'b0;
         if (!rstn)
         begin
            txBuf_reg <= 8'h00;
            rxBuf_reg <= 8'h00;
         end
      end
      else
      begin
         if (txAccept)
         begin
            txBuf_reg      <= regWdata[7:0];
            txBufValid_reg <= 1'b1;
            tbemp_reg      <= 1'b0;
         end
         else if (txLoad)
         begin
            txBufValid_reg <= 1'b0;
            tbemp_reg      <= 1'b1;
         end
         txrun_reg <= (txState_reg != TX_IDLE & !txEnd) | txLoad;
         // word arrives; read clears unless a word lands now
         if (rxDone)
         begin
            rxBuf_reg <= rxWord;
            rbfll_reg <= 1'b1;
         end
         else if (rdMode2)
            rbfll_reg <= 1'b0;
         if (rxOver)
            oerr_reg <= 1'b1;
         if (rxDone & rxFerr)
            ferr_reg <= 1'b1;
      end
   end

   // ==========================================================
   // configuration registers
   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         sblen_reg <= 1'b0;
         order_reg <= 1'b0;
         wbuf_reg  <= 1'b0;
         soft_reset_field_reg <= 2'b00;
         ioMode_reg     <= 1'b0;
         sclkOutSel_reg <= 1'b0;
      end
      else
      begin
         if (wrMode2)
         begin
            sblen_reg <= regWdata[`BIT_SBLEN];
            order_reg <= regWdata[`BIT_ORDER];
            wbuf_reg  <= regWdata[`BIT_WBUF];
            soft_reset_field_reg <= newRst;
         end
         if (wrCtrl)
         begin
            ioMode_reg     <= regWdata[`BIT_IOMODE];
            sclkOutSel_reg <= regWdata[`BIT_SCLKOUT];
         end
      end
   end

   // enables cleared by soft reset as well
   always_ff @(posedge mclk)
   begin
      if (!rstn || swExec)
      begin
         rxe_reg <= 1'b0;
         txe_reg <= 1'b0;
      end
      else if (wrCtrl)
      begin
         rxe_reg <= regWdata[`BIT_RXE];
         txe_reg <= regWdata[`BIT_TXE];
      end
   end

   // ==========================================================
   // interrupts: sticky, write one to clear, event wins
   wire [3:0] irqEvt = {rxDone & rxFerr, rxOver, rxDone, txLoad};
   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         irqStat_reg <= 4'h0;
         irqMask_reg <= 4'h0;
      end
      else
      begin
         irqStat_reg <= (irqStat_reg & ~(wrStat ? regWdata[3:0] : 4'h0)) | irqEvt;
         if (wrMask)
            irqMask_reg <= regWdata[3:0];
      end
   end
   assign irq = |(irqStat_reg & irqMask_reg);

   // ==========================================================
   // read mux, data one cycle after the strobe; unmapped reads zero
   // shown unbuffered too
   wire [7:0] mode2Val = {tbemp_reg, rbfll_reg, txrun_reg, sblen_reg,
                          order_reg, wbuf_reg, soft_reset_field_reg};
   wire [31:0] rdMux =
      hit(regAddr, `ADDR_MODE2)      ? {24'h000000, mode2Val} :
      hit(regAddr, `ADDR_IRQ_STATUS) ? {28'h0000000, irqStat_reg} :
      hit(regAddr, `ADDR_IRQ_MASK)   ? {28'h0000000, irqMask_reg} :
      hit(regAddr, `ADDR_CTRL)       ? {28'h0000000, sclkOutSel_reg, ioMode_reg,
                                        txe_reg, rxe_reg} :
      hit(regAddr, `ADDR_ERROR)      ? {29'h00000000, ferr_reg, perr_reg, oerr_reg} :
      hit(regAddr, `ADDR_RXDATA)     ? {24'h000000, rxBuf_reg} : 32'h00000000;
   always_ff @(posedge mclk)
   begin
      if (!rstn)
         regRdata <= 32'h00000000;
      else
         regRdata <= regRead ? rdMux : 32'h00000000;
   end
endmodule

`default_nettype wire

// File: sim/serial_mode2_asserts.sv
// port-level checker for the mode2 status block
// assumes the cfg header is on the include path; bound below
`timescale 1ns/1ps
`default_nettype none
`include "serial_mode2_cfg.svh"

module serial_mode2_asserts
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rstn,
   // register port
   input  wire logic [7:0]  regAddr,
   input  wire logic [31:0] regWdata,
   input  wire logic        regWrite,
   input  wire logic        regRead,
   input  wire logic [31:0] regRdata,
   // link and interrupt
   input  wire logic        txdPin,
   input  wire logic        irq
);
   // ==========
   // shadows of what software wrote
   logic       armReg;
   logic [4:0] cfgReg;
   logic [3:0] maskReg;
   logic [3:0] swCnt;
   wire        m2Wr = regWrite && regAddr == `ADDR_MODE2;
   wire        m2Rd = regRead && regAddr == `ADDR_MODE2;
   wire        fire = m2Wr && armReg && regWdata[1:0] == `SOFT_RESET_FIELD_FIRE;

   // swCnt blanks the a_bit_width line check while a soft reset cuts a frame short
   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         armReg  <= 1'b0;
         cfgReg  <= 5'h00;
         maskReg <= 4'h0;
         swCnt   <= 4'h0;
      end
      else
      begin
         if (m2Wr) armReg <= regWdata[1:0] == `SOFT_RESET_FIELD_ARM;
         if (m2Wr) cfgReg <= regWdata[4:0];
         if (regWrite && regAddr == `ADDR_IRQ_MASK) maskReg <= regWdata[3:0];
         swCnt <= fire ? 4'hf : swCnt - {3'h0, swCnt != 4'h0};
      end
   end

   // ==========
   // properties
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   a_rdata_idle: assert property (!$past(regRead) |-> regRdata == 32'h0)
      else $error("read data not zero outside a read answer");
   a_rdata_upper: assert property (m2Rd |=> regRdata[31:8] == 24'h0)
      else $error("mode2 upper bits not zero");
   a_unmapped_zero: assert property (regRead && regAddr > 8'h18 |=> regRdata == 32'h0)
      else $error("unmapped read not zero");
   a_cfg_readback: assert property (m2Rd |=> regRdata[4:0] == $past(cfgReg))
      else $error("mode2 settings read back wrong");
   a_irq_masked: assert property (maskReg == 4'h0 |-> !irq)
      else $error("interrupt high with all sources masked");
   a_rbfll_clear: assert property (m2Rd ##1 m2Rd |=> !regRdata[6])
      else $error("full flag survived a read");
   a_bit_width: assert property (disable iff (!rstn || fire || swCnt != 4'h0)
      $fell(txdPin) |-> !txdPin [*8])
      else $error("serial line low pulse too short");
   a_soft_reset_field_idle: assert property (fire |-> ##4 txdPin [*8])
      else $error("line not idle after soft reset");

   // main scenarios reached
   c_soft_reset: cover property (fire);
   c_double_read: cover property (m2Rd ##1 m2Rd);
   c_frame_start: cover property ($fell(txdPin));
endmodule

bind serial_mode2_status_control serial_mode2_asserts u_serial_mode2_asserts
(
   .mclk(mclk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
   .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
   .txdPin(txdPin), .irq(irq)
);
`default_nettype wire

// File: sim/serial_link_peer.sv
// remote serial peer: uart frames and io frames on its own link clock
// assumes a 160 ns bit time; link clock idles high between frames
`timescale 1ns/1ps
`default_nettype none

module serial_link_peer
(
   // clock
   input  wire logic mclk,
   // link
   input  wire logic txdPin,
   output logic      rxdPin,
   output logic      sclkPin
);
   logic [7:0] uCap;
   logic [7:0] ioCap;
   int         nFrames = 0;
   time        lastStart = 0;
   time        gap = 0;

   // idle mark level on both lines
   initial
   begin
      rxdPin  = 1'b1;
      sclkPin = 1'b1;
   end

   // uart frame, lsb first; stops 0 sends a low stop bit then mark
   task automatic sendUart(input logic [7:0] d, input int stops);
      logic [10:0] f;
      f = {2'b11, d, 1'b0};
      if (stops == 0) f[9] = 1'b0;
      for (int i = 0; i < (stops == 0 ? 11 : 9 + stops); i++)
      begin
         rxdPin <= f[i];
         repeat (16) @(posedge mclk);
      end
   endtask

   // io frame: drive on falling, capture on rising, clock parked high after
   task automatic ioFrame(input logic [7:0] d);
      #3;
      for (int i = 0; i < 8; i++)
      begin
         sclkPin = 1'b0;
         rxdPin  = d[i];
         #80;
         sclkPin = 1'b1;
         ioCap[i] = txdPin;
         #80;
      end
      rxdPin = ~d[7];
   endtask

   // start spacing and mid-bit samples of frames from the block
   always
   begin
      @(negedge txdPin);
      gap       = $time - lastStart;
      lastStart = $time;
      #80;
      for (int i = 0; i < 8; i++)
      begin
         #160;
         uCap[i] = txdPin;
      end
      nFrames++;
   end
endmodule
`default_nettype wire

// File: sim/serial_mode2_status_control_tb.sv
// self-checking bench for the mode2 status block with a serial peer
// assumes the cfg header is on the include path
`timescale 1ns/1ps
`default_nettype none
`include "serial_mode2_cfg.svh"

module serial_mode2_status_control_tb;
   import serial_mode2_pkg::*;
   logic        mclk;
   logic        rstn = 1'b0;
   logic        regWrite = 1'b0;
   logic        regRead = 1'b0;
   logic [7:0]  regAddr = 8'h00;
   logic [31:0] regWdata = 32'h0;
   logic [31:0] regRdata;
   logic [31:0] q [2];
   wire logic   rxdPin, sclkPin, txdPin, sclkOut, sclkOutEnN, irq;
   int          mismatches = 0;
   int          checksDone = 0;
   int          n0;

   serial_mode2_status_control u_serial_mode2_status_control
   (
      .mclk(mclk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
      .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
      .rxdPin(rxdPin), .sclkPin(sclkPin), .txdPin(txdPin), .sclkOut(sclkOut),
      .sclkOutEnN(sclkOutEnN), .irq(irq)
   );
   serial_link_peer u_serial_link_peer
   (
      .mclk(mclk), .txdPin(txdPin), .rxdPin(rxdPin), .sclkPin(sclkPin)
   );

   // 100 MHz clock
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // ==========
   // bus and compare helpers
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checksDone++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      regAddr  <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge mclk);
      regWrite <= 1'b0;
   endtask
   // n back-to-back reads of one address; answers land in q
   task automatic rdb(input logic [7:0] a, input int n);
      @(posedge mclk);
      regAddr <= a;
      regRead <= 1'b1;
      for (int i = 0; i < n; i++)
      begin
         @(posedge mclk);
         if (i == n - 1) regRead <= 1'b0;
         #1 q[i] = regRdata;
      end
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      rdb(a, 1);
      check(q[0] & m, e);
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", checksDone, mismatches);
      if (mismatches == 0 && checksDone > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // hang guard, far beyond the few thousand cycles the tests need
   initial
   begin
      repeat (20000) @(posedge mclk);
      mismatches++;
      results();
   end

   // ==========
   // tests
   initial
   begin
      idle(20);
      rstn <= 1'b1;
      rc(`ADDR_MODE2, 32'hffffffff, 32'h80);
      wr(`ADDR_MODE2, 32'hff);
      rc(`ADDR_MODE2, 32'hffffffff, 32'h9f);
      rc(8'h40, 32'hffffffff, 32'h0);
      $display("test registers done");
      // second byte waits in the buffer while the first is on the line
      wr(`ADDR_CTRL, 32'h02);
      for (int s = 0; s < 2; s++)
      begin
         wr(`ADDR_IRQ_MASK, 32'(1 - s));
         wr(`ADDR_MODE2, 32'(4 + 16 * s));
         n0 = u_serial_link_peer.nFrames;
         wr(`ADDR_TXDATA, 32'h55);
         idle(4);
         wr(`ADDR_TXDATA, 32'ha3);
         idle(4);
         rc(`ADDR_MODE2, 32'he0, 32'h20);
         for (int k = 0; k < 600 && u_serial_link_peer.nFrames < n0 + 2; k++) idle(1);
         check({24'h0, u_serial_link_peer.uCap}, 32'ha3);
         check(32'(u_serial_link_peer.gap >= 1600 + 160 * s
                   && u_serial_link_peer.gap <= 1620 + 160 * s), 32'h1);
         idle(250);
         rc(`ADDR_MODE2, 32'he0, 32'h80);
         check({31'h0, irq}, 32'(1 - s));
         rc(`ADDR_IRQ_STATUS, 32'h1, 32'h1);
         wr(`ADDR_IRQ_STATUS, 32'h1);
         rc(`ADDR_IRQ_STATUS, 32'h1, 32'h0);
         check({31'h0, irq}, 32'h0);
      end
      $display("test transmit done");
      // receive is buffered even with buffering off; one stop bit suffices
      wr(`ADDR_MODE2, 32'h10);
      wr(`ADDR_CTRL, 32'h01);
      fork
         begin
            u_serial_link_peer.sendUart(8'h3c, 1);
            u_serial_link_peer.sendUart(8'hc3, 1);
         end
         begin
            q[0] = 32'h0;
            for (int k = 0; k < 300 && q[0][6] !== 1'b1; k++) rdb(`ADDR_MODE2, 1);
            rc(`ADDR_RXDATA, 32'hff, 32'h3c);
         end
      join
      idle(40);
      rdb(`ADDR_MODE2, 2);
      check(q[0] & 32'h40, 32'h40);
      check(q[1] & 32'h40, 32'h0);
      rc(`ADDR_RXDATA, 32'hff, 32'hc3);
      rc(`ADDR_ERROR, 32'h7, 32'h0);
      u_serial_link_peer.sendUart(8'h5a, 0);
      idle(40);
      rc(`ADDR_ERROR, 32'h4, 32'h4);
      $display("test receive done");
      // reset sequence twice, the first while a frame is on the line
      wr(`ADDR_CTRL, 32'h03);
      wr(`ADDR_MODE2, 32'h04);
      wr(`ADDR_TXDATA, 32'h00);
      idle(4);
      wr(`ADDR_TXDATA, 32'h0f);
      idle(40);
      for (int r = 0; r < 2; r++)
      begin
         wr(`ADDR_MODE2, 32'h06);
         wr(`ADDR_MODE2, 32'h05);
      end
      idle(4);
      rc(`ADDR_MODE2, 32'he0, 32'h80);
      rc(`ADDR_CTRL, 32'h3, 32'h0);
      rc(`ADDR_ERROR, 32'h7, 32'h0);
      // the clear lands on the second edge after the firing write
      wr(`ADDR_CTRL, 32'h03);
      wr(`ADDR_MODE2, 32'h02);
      wr(`ADDR_MODE2, 32'h01);
      rdb(`ADDR_CTRL, 2);
      check(q[0] & 32'h3, 32'h3);
      check(q[1] & 32'h3, 32'h0);
      $display("test soft reset done");
      // io mode on the peer's clock, both bit orders, then internal clock
      wr(`ADDR_CTRL, 32'h07);
      for (int o = 0; o < 2; o++)
      begin
         wr(`ADDR_MODE2, 32'(4 + 8 * o));
         wr(`ADDR_TXDATA, 32'hcb);
         idle(10);
         check({31'h0, sclkOutEnN}, 32'h1);
         u_serial_link_peer.ioFrame(8'h96);
         idle(20);
         check({24'h0, u_serial_link_peer.ioCap}, o ? 32'hd3 : 32'hcb);
         rc(`ADDR_RXDATA, 32'hff, o ? 32'h69 : 32'h96);
         rdb(`ADDR_MODE2, 1);
      end
      wr(`ADDR_CTRL, 32'h0f);
      idle(2);
      check({31'h0, sclkOutEnN}, 32'h0);
      wr(`ADDR_TXDATA, 32'h01);
      idle(20);
      check({31'h0, sclkOut}, 32'h0);
      $display("test io mode done");
      results();
   end
endmodule
`default_nettype wire
